// ### sss_pkg.sv
// constants and types shared by the synchronous sram with sleep control
package sss_pkg;

	// array geometry
	localparam int ADDR_W  = 6;
	localparam int DATA_W  = 8;
	localparam int BURST_W = 2;

	// clock and sleep timing, times in picoseconds
	localparam int CLK_PERIOD_PS                = 4000;
	localparam int SLEEP_INPUT_IGNORE_DELAY_PS  = 2 * CLK_PERIOD_PS;
	localparam int WAKE_INPUT_SAMPLE_DELAY_PS   = 2 * CLK_PERIOD_PS;
	localparam int SLEEP_CURRENT_DELAY_PS       = 2 * CLK_PERIOD_PS;

	// longest times round down to whole cycles
	localparam int SLEEP_INPUT_IGNORE_CYC = SLEEP_INPUT_IGNORE_DELAY_PS / CLK_PERIOD_PS;
	localparam int WAKE_INPUT_SAMPLE_CYC  = WAKE_INPUT_SAMPLE_DELAY_PS / CLK_PERIOD_PS;
	localparam int SLEEP_CURRENT_CYC      = SLEEP_CURRENT_DELAY_PS / CLK_PERIOD_PS;
	localparam logic [1:0] WAKE_GUARD_CNT = 2'(WAKE_INPUT_SAMPLE_CYC);

	// register map, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;

	// control fields
	localparam int   CTRL_GUARD_BIT = 0;
	localparam logic CTRL_GUARD_RST = 1'b0;

	// status fields
	localparam int STAT_SLEEP_BIT  = 0;
	localparam int STAT_WAKE_BIT   = 1;
	localparam int STAT_BUSY_BIT   = 2;
	localparam int STAT_WRDROP_BIT = 3;
	localparam int STAT_ORDER_BIT  = 4;

	// power state, gray along run -> sleep -> wake; wake -> run flips both bits
	typedef enum logic [1:0] {
		SSS_PWR_RUN   = 2'b00,
		SSS_PWR_SLEEP = 2'b01,
		SSS_PWR_WAKE  = 2'b11
	} sss_pwr_t;

endpackage : sss_pkg

// ### sss_sram.sv
// pipelined synchronous sram core with sleep, stall, burst and wishbone status port
//
// Summary of operation
// - the sleep request pin is synchronised as an asynchronous active-high level and puts the device to sleep.
// - asleep, the device is deselected, ignores every memory pin but the sleep request and releases the data bus.
// - the device sleeps exactly while the synchronised sleep request is high and wakes when it falls.
// - synchronous inputs stop being honoured within two clock periods of the sleep request rising.
// - synchronous inputs are sampled again within two clock periods of the sleep request falling.
// - the low-power indication is reached within two clock periods of the sleep request rising.
// - burst order input low gives linear address order and high gives interleaved order.
// - bursts are optional and single-address cycles alone work correctly.
// - the device is selected only when both low-active selects are 0 and the high-active select is 1.
// - a read returns the newest written value, forwarded from the pending write register when needed.
// - an inactive clock-gate input stalls that edge and no write is performed in it.
// - a load cycle is a write when read/write is low and a read when it is high.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

module sss_sram #(
	parameter int ADDR_W  = sss_pkg::ADDR_W,
	parameter int DATA_W  = sss_pkg::DATA_W,
	parameter int BURST_W = sss_pkg::BURST_W
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// memory pins, synchronous to clk_i except the sleep request
	input  wire logic              sleep_request_i,
	input  wire logic              edge_enable_n_i,
	input  wire logic              chip_select_n_i,
	input  wire logic              chip_select_low_b_i,
	input  wire logic              chip_select_high_i,
	input  wire logic              advance_load_n_i,
	input  wire logic              read_write_n_i,
	input  wire logic              burst_order_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] dq_i,
	output logic      [DATA_W-1:0] dq_o,
	output logic                   dq_oe_o,
	output logic                   low_power_o,
	// wishbone classic slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic selected_f(input logic a_n, input logic b_n, input logic c);
		selected_f = !a_n && !b_n && c;
	endfunction : selected_f

	// low bits follow the burst counter, high bits stay at the loaded base
	function automatic logic [ADDR_W-1:0] burst_addr_f(input logic [ADDR_W-1:0] base,
			input logic [BURST_W-1:0] cnt, input logic order);
		logic [BURST_W-1:0] low;
		low = order ? (base[BURST_W-1:0] ^ cnt) : BURST_W'(base[BURST_W-1:0] + cnt);
		burst_addr_f = {base[ADDR_W-1:BURST_W], low};
	endfunction : burst_addr_f

	////////////////////////////////////////////////////////////////////////////
	// sleep request synchroniser and power state

	logic              sleep_s1_q;
	logic              sleep_s2_q;
	sss_pkg::sss_pwr_t pwr_q;
	sss_pkg::sss_pwr_t pwr_d;
	logic [1:0]        wake_cnt_q;
	logic [1:0]        wake_cnt_d;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sleep_s1_q <= 1'b0;
			sleep_s2_q <= 1'b0;
		end else if (ce_i) begin
			sleep_s1_q <= sleep_request_i;
			sleep_s2_q <= sleep_s1_q;
		end
	end

	wire sleeping = sleep_s2_q;

	always_comb begin
		pwr_d      = pwr_q;
		wake_cnt_d = wake_cnt_q;
		unique case (pwr_q)
			sss_pkg::SSS_PWR_RUN: begin
				if (sleeping) pwr_d = sss_pkg::SSS_PWR_SLEEP;
			end
			sss_pkg::SSS_PWR_SLEEP: begin
				if (!sleeping) begin
					pwr_d      = sss_pkg::SSS_PWR_WAKE;
					wake_cnt_d = sss_pkg::WAKE_GUARD_CNT;
				end
			end
			sss_pkg::SSS_PWR_WAKE: begin
				if (sleeping) begin
					pwr_d = sss_pkg::SSS_PWR_SLEEP;
				end else if (wake_cnt_q <= 2'h1) begin
					pwr_d      = sss_pkg::SSS_PWR_RUN;
					wake_cnt_d = 2'h0;
				end else begin
					wake_cnt_d = wake_cnt_q - 2'h1;
				end
			end
			default: pwr_d = sss_pkg::SSS_PWR_SLEEP;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_q      <= sss_pkg::SSS_PWR_RUN;
			wake_cnt_q <= 2'h0;
		end else if (ce_i) begin
			pwr_q      <= pwr_d;
			wake_cnt_q <= wake_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command decode

	logic              guard_en_q;
	logic              act_q;
	logic              act_wr_q;
	logic              order_q;
	logic [ADDR_W-1:0] base_q;
	logic [BURST_W-1:0] cnt_q;
	logic              s1_v_q;
	logic              s1_wr_q;
	logic [ADDR_W-1:0] s1_addr_q;
	logic              s2_v_q;
	logic              s2_wr_q;
	logic [ADDR_W-1:0] s2_addr_q;

	// inputs count only on an enabled edge outside sleep
	wire take       = ce_i && !edge_enable_n_i && !sleeping;
	wire load       = !advance_load_n_i;
	wire sel        = selected_f(chip_select_n_i, chip_select_low_b_i, chip_select_high_i);
	wire new_cmd    = load && sel;
	wire is_write   = !read_write_n_i;
	// writes inside the wake window are refused only when the guard is armed
	wire guard_drop = guard_en_q && (pwr_q == sss_pkg::SSS_PWR_WAKE);
	wire cmd_v      = new_cmd ? !(is_write && guard_drop) : (!load && act_q);
	wire [BURST_W-1:0] next_cnt = BURST_W'(cnt_q + 1'b1);
	wire [ADDR_W-1:0]  burst_a  = burst_addr_f(base_q, next_cnt, order_q);
	wire               wr_drop  = take && new_cmd && is_write && guard_drop;

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && sleeping)) begin
			act_q  <= 1'b0;
			s1_v_q <= 1'b0;
		end else if (take) begin
			if (load) begin
				act_q    <= new_cmd && cmd_v;
				act_wr_q <= is_write;
				base_q   <= addr_i;
				order_q  <= burst_order_i;
				cnt_q    <= '0;
			end else if (act_q) begin
				cnt_q    <= next_cnt;
			end
			s1_v_q    <= cmd_v;
			s1_wr_q   <= load ? is_write : act_wr_q;
			s1_addr_q <= load ? addr_i : burst_a;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data pipeline, array and pending write register

	logic [DATA_W-1:0] mem_q [2**ADDR_W];
	logic              pend_v_q;
	logic [ADDR_W-1:0] pend_a_q;
	logic [DATA_W-1:0] pend_d_q;
	logic [DATA_W-1:0] dout_q;
	logic              oe_q;

	wire hit       = pend_v_q && (pend_a_q == s2_addr_q);
	wire capture   = take && s2_v_q && s2_wr_q;
	wire rd_issue  = take && s2_v_q && !s2_wr_q;
	// a stalled edge commits nothing; during sleep the pending word still lands
	wire commit    = ce_i && pend_v_q && (sleeping || !edge_enable_n_i);

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && sleeping)) begin
			s2_v_q <= 1'b0;
			oe_q   <= 1'b0;
		end else if (take) begin
			s2_v_q    <= s1_v_q;
			s2_wr_q   <= s1_wr_q;
			s2_addr_q <= s1_addr_q;
			oe_q      <= rd_issue;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rd_issue) begin
			dout_q <= hit ? pend_d_q : mem_q[s2_addr_q];
		end
	end

	always_ff @(posedge clk_i) begin
		if (commit) begin
			mem_q[pend_a_q] <= pend_d_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_v_q <= 1'b0;
		end else if (capture) begin
			pend_v_q <= 1'b1;
			pend_a_q <= s2_addr_q;
			pend_d_q <= dq_i;
		end else if (commit) begin
			pend_v_q <= 1'b0;
		end
	end

	assign dq_o        = dout_q;
	assign dq_oe_o     = oe_q && !sleeping;
	assign low_power_o = sleeping;

	////////////////////////////////////////////////////////////////////////////
	// wishbone registers

	logic ack_q;
	logic wrdrop_q;
	logic [31:0] rdat_q;

	wire wb_req   = wb_cyc_i && wb_stb_i && !ack_q;
	wire wb_wr    = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
	wire hit_ctrl = wb_adr_i == sss_pkg::REG_CTRL;
	wire hit_stat = wb_adr_i == sss_pkg::REG_STATUS;
	wire busy     = s1_v_q || s2_v_q || pend_v_q;
	wire clr_drop = wb_wr && hit_stat && wb_dat_i[sss_pkg::STAT_WRDROP_BIT];

	wire [31:0] stat_word = {27'h00_0000, order_q, wrdrop_q, busy,
		pwr_q == sss_pkg::SSS_PWR_WAKE, sleeping};
	wire [31:0] ctrl_word = {31'h000_0000, guard_en_q};
	wire [31:0] rd_mux    = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0000_0000);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q      <= 1'b0;
			guard_en_q <= sss_pkg::CTRL_GUARD_RST;
			wrdrop_q   <= 1'b0;
			rdat_q     <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_q  <= wb_req;
			rdat_q <= wb_req ? rd_mux : rdat_q;
			if (wb_wr && hit_ctrl) begin
				guard_en_q <= wb_dat_i[sss_pkg::CTRL_GUARD_BIT];
			end
			// a refused write in the clearing cycle keeps the flag set
			wrdrop_q <= wr_drop || (wrdrop_q && !clr_drop);
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	a_sleep_entry: assert property (sleep_request_i [*2] |=> low_power_o)
		else $error("sleep request not honoured within two edges");

	a_sleep_hiz: assert property (low_power_o |-> !dq_oe_o ##1 (!s1_v_q && !s2_v_q))
		else $error("bus driven or command live during sleep");

	a_sleep_exit: assert property (!sleep_request_i [*2] |=> !low_power_o)
		else $error("sleep held after request released");

	a_inputs_ignored: assert property (low_power_o && !advance_load_n_i |=> !s1_v_q)
		else $error("command taken while asleep");

	a_wake_sample: assert property (!sleep_request_i [*2] ##1 (!edge_enable_n_i
			&& !advance_load_n_i && chip_select_high_i && !chip_select_n_i
			&& !chip_select_low_b_i && read_write_n_i) |=> s1_v_q)
		else $error("read not sampled after wake");

	a_burst_order: assert property (take && new_cmd ##1 take && !load && act_q
			|=> s1_addr_q[1:0] == ($past(burst_order_i, 2)
			? ($past(addr_i[1:0], 2) ^ 2'b01) : 2'($past(addr_i[1:0], 2) + 2'b01)))
		else $error("burst address order wrong");

	a_select_three: assert property (take && load && (chip_select_n_i
			|| chip_select_low_b_i || !chip_select_high_i) |=> !s1_v_q)
		else $error("command taken while deselected");

	a_read_forward: assert property (rd_issue && hit |=> dout_q == $past(pend_d_q))
		else $error("read missed pending write data");

	a_stall_nowrite: assert property (edge_enable_n_i && !low_power_o && pend_v_q
			|=> pend_v_q && $stable(pend_a_q))
		else $error("write performed on stalled edge");

	a_cycle_kind: assert property (take && new_cmd && !guard_drop
			|=> s1_v_q && (s1_wr_q == !$past(read_write_n_i)))
		else $error("read or write decoded wrongly");

	a_fresh_wake: assert property ($fell(low_power_o) |-> !s1_v_q && !s2_v_q && !act_q)
		else $error("operation pending after wake");

	c_burst_run: cover property (take && new_cmd ##1 (take && !load && act_q) [*3]);
	c_forward_hit: cover property (rd_issue && hit);
	c_sleep_cycle: cover property ($rose(low_power_o) ##[1:20] $fell(low_power_o));
	c_stall_write: cover property (capture ##1 edge_enable_n_i && pend_v_q);

endmodule : sss_sram

// ### sss_ctrl_model.sv
// memory controller model that drives the sram pins, one command per clock
`timescale 1ns/1ps
module sss_ctrl_model (
	input  wire logic                  clk_i,
	output logic                       edge_enable_n_o,
	output logic                       chip_select_n_o,
	output logic                       chip_select_low_b_o,
	output logic                       chip_select_high_o,
	output logic                       advance_load_n_o,
	output logic                       read_write_n_o,
	output logic                       burst_order_o,
	output logic [sss_pkg::ADDR_W-1:0] addr_o,
	output logic [sss_pkg::DATA_W-1:0] dq_o
);
	logic [sss_pkg::DATA_W-1:0] wd_q;
	logic [sss_pkg::DATA_W-1:0] s1_q;
	logic                       s1_v_q;
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		// idle is a deselect load: a free-running advance would extend a burst
		{edge_enable_n_o, chip_select_n_o, chip_select_low_b_o, chip_select_high_o} = 4'h5;
		{advance_load_n_o, read_write_n_o, burst_order_o} = 3'h2;
		addr_o = '0;
		dq_o = '0;
		wd_q = '0;
		s1_q = '0;
		s1_v_q = 1'b0;
	end
	// op: 0 deselect, 1 read, 2 write, 3 advance, 4 and 5 read with one select off, 6 stalled write
	task automatic drive(input logic [2:0] op, input logic [sss_pkg::ADDR_W-1:0] a,
		input logic [sss_pkg::DATA_W-1:0] d, input logic ord);
		edge_enable_n_o     <= (op == 3'h6);
		chip_select_n_o     <= (op == 3'h0);
		chip_select_low_b_o <= (op == 3'h4);
		chip_select_high_o  <= (op != 3'h5);
		advance_load_n_o    <= (op == 3'h3);
		read_write_n_o      <= (op != 3'h2) && (op != 3'h6);
		burst_order_o       <= ord;
		addr_o              <= a;
		wd_q                <= d;
	endtask : drive
	////////////////////////////////////////////////////////////////////////////////
	// write data goes out on the second taken edge; a released bus toggles so stale data shows
	always @(posedge clk_i) begin
		if (!edge_enable_n_o) begin
			s1_v_q <= !advance_load_n_o && !read_write_n_o && !chip_select_n_o
				&& !chip_select_low_b_o && chip_select_high_o;
			s1_q   <= wd_q;
			dq_o   <= s1_v_q ? s1_q : ~dq_o;
		end
	end
endmodule : sss_ctrl_model

// ### sync_sram_sleep_and_control_tb.sv
// self-checking testbench for the synchronous sram with sleep control
`timescale 1ns/1ps
module sync_sram_sleep_and_control_tb;
	typedef struct packed {
		logic [2:0]                 op;
		logic [sss_pkg::ADDR_W-1:0] a;
		logic                       ord;
		logic                       oe;
		logic [sss_pkg::DATA_W-1:0] q;
	} sss_row_t;
	localparam int NROW = 24;
	logic                       clk_i, rst_i, sleep_req;
	logic                       ee_n, cs_n, cs_low_b, cs_high, adv_n, rw_n, ord_w, rd_oe, low_pwr;
	logic [sss_pkg::ADDR_W-1:0] addr;
	logic [sss_pkg::DATA_W-1:0] wdat, rdat;
	logic                       wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0]                 wb_adr;
	logic [31:0]                wb_wdat, wb_rdat, q;
	logic [3:0]                 wb_sel;
	int                         err_total, check_count, cyc_cnt;
	sss_row_t                   rows [NROW];
	////////////////////////////////////////////////////////////////////////////////
	sss_sram sss_sram_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.sleep_request_i(sleep_req), .edge_enable_n_i(ee_n), .chip_select_n_i(cs_n),
		.chip_select_low_b_i(cs_low_b), .chip_select_high_i(cs_high),
		.advance_load_n_i(adv_n), .read_write_n_i(rw_n), .burst_order_i(ord_w),
		.addr_i(addr), .dq_i(wdat), .dq_o(rdat), .dq_oe_o(rd_oe), .low_power_o(low_pwr),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
	sss_ctrl_model sss_ctrl_model_inst (.clk_i(clk_i), .edge_enable_n_o(ee_n),
		.chip_select_n_o(cs_n), .chip_select_low_b_o(cs_low_b), .chip_select_high_o(cs_high),
		.advance_load_n_o(adv_n), .read_write_n_o(rw_n), .burst_order_o(ord_w),
		.addr_o(addr), .dq_o(wdat));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we, wb_sel} <= {2'b11, we, 4'hF};
		wb_adr  <= a;
		wb_wdat <= d;
		// no cycle count is assumed; the bench timeout ends a hang
		while (wb_ack !== 1'b1) @(posedge clk_i);
		chk(wb_ack, 32'h0000_0001);
		rd = wb_rdat;
		{wb_cyc, wb_stb, wb_we} <= 3'h0;
	endtask : wb_xfer
	task automatic results();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 1000) begin
			err_total++;
			$display("Error at %0t: timeout", $time);
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_i, sleep_req, wb_cyc, wb_stb, wb_we, wb_sel} = {1'b1, 4'h0, 4'h0};
		{wb_adr, wb_wdat} = '0;
		{err_total, check_count, cyc_cnt} = '0;
		// op, address, burst order, read drives bus, read data or write data
		rows = '{'{3'h2, 6'h01, 1'b0, 1'b0, 8'h11}, '{3'h2, 6'h02, 1'b0, 1'b0, 8'h22},
			'{3'h2, 6'h03, 1'b0, 1'b0, 8'h33}, '{3'h2, 6'h00, 1'b0, 1'b0, 8'h44},
			'{3'h1, 6'h01, 1'b0, 1'b1, 8'h11}, '{3'h2, 6'h05, 1'b0, 1'b0, 8'h5A},
			'{3'h1, 6'h05, 1'b0, 1'b1, 8'h5A}, '{3'h1, 6'h01, 1'b0, 1'b1, 8'h11},
			'{3'h3, 6'h00, 1'b0, 1'b1, 8'h22}, '{3'h3, 6'h00, 1'b0, 1'b1, 8'h33},
			'{3'h3, 6'h00, 1'b0, 1'b1, 8'h44}, '{3'h1, 6'h01, 1'b1, 1'b1, 8'h11},
			'{3'h3, 6'h00, 1'b1, 1'b1, 8'h44}, '{3'h3, 6'h00, 1'b1, 1'b1, 8'h33},
			'{3'h3, 6'h00, 1'b1, 1'b1, 8'h22}, '{3'h4, 6'h01, 1'b0, 1'b0, 8'h00},
			'{3'h5, 6'h01, 1'b0, 1'b0, 8'h00}, '{3'h0, 6'h01, 1'b0, 1'b0, 8'h00},
			'{3'h3, 6'h00, 1'b0, 1'b0, 8'h00}, '{3'h2, 6'h07, 1'b0, 1'b0, 8'h70},
			'{3'h0, 6'h00, 1'b0, 1'b0, 8'h00}, '{3'h0, 6'h00, 1'b0, 1'b0, 8'h00},
			'{3'h6, 6'h07, 1'b0, 1'b0, 8'h7F}, '{3'h1, 6'h07, 1'b0, 1'b1, 8'h70}};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({rd_oe, low_pwr, wb_ack}, 32'h0000_0000);
		wb_xfer(1'b1, sss_pkg::REG_CTRL, 32'h0000_0001, q);
		wb_xfer(1'b0, sss_pkg::REG_CTRL, 32'h0000_0000, q);
		chk(q, 32'h0000_0001);
		wb_xfer(1'b1, 8'h08, 32'hFFFF_FFFF, q);
		wb_xfer(1'b0, 8'h08, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		// read data appears after the second edge behind the command edge
		for (int i = 0; i < NROW + 3; i++) begin
			@(posedge clk_i);
			if (i < NROW) begin
				sss_ctrl_model_inst.drive(rows[i].op, rows[i].a, rows[i].q, rows[i].ord);
			end else begin
				sss_ctrl_model_inst.drive(3'h0, 6'h00, 8'h00, 1'b0);
			end
			@(negedge clk_i);
			if (i >= 3) begin
				chk(rd_oe, rows[i-3].oe);
				if (rows[i-3].oe) chk(rdat, rows[i-3].q);
			end
		end
		@(posedge clk_i);
		sleep_req <= 1'b1;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk({low_pwr, rd_oe}, 32'h0000_0002);
		@(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h2, 6'h02, 8'hEE, 1'b0);
		@(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h1, 6'h02, 8'h00, 1'b0);
		@(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h0, 6'h00, 8'h00, 1'b0);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk({low_pwr, rd_oe}, 32'h0000_0002);
		wb_xfer(1'b0, sss_pkg::REG_STATUS, 32'h0000_0000, q);
		chk(q & 32'h0000_0001, 32'h0000_0001);
		@(posedge clk_i);
		sleep_req <= 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk(low_pwr, 32'h0000_0000);
		@(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h1, 6'h02, 8'h00, 1'b0);
		@(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h0, 6'h00, 8'h00, 1'b0);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk(rd_oe, 32'h0000_0001);
		chk(rdat, 32'h0000_0022);
		// second sleep: the armed guard drops a write inside the wake window
		@(posedge clk_i);
		sleep_req <= 1'b1;
		repeat (4) @(posedge clk_i);
		sleep_req <= 1'b0;
		repeat (3) @(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h2, 6'h02, 8'hDD, 1'b0);
		@(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h0, 6'h00, 8'h00, 1'b0);
		wb_xfer(1'b0, sss_pkg::REG_STATUS, 32'h0000_0000, q);
		chk(q, 32'h0000_0008);
		@(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h1, 6'h02, 8'h00, 1'b0);
		@(posedge clk_i);
		sss_ctrl_model_inst.drive(3'h0, 6'h00, 8'h00, 1'b0);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk(rd_oe, 32'h0000_0001);
		chk(rdat, 32'h0000_0022);
		// the dropped-write flag clears by writing one to it
		wb_xfer(1'b1, sss_pkg::REG_STATUS, 32'h0000_0008, q);
		wb_xfer(1'b0, sss_pkg::REG_STATUS, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		// mid-run reset returns the guard to its reset value
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_xfer(1'b0, sss_pkg::REG_CTRL, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		results();
	end
endmodule : sync_sram_sleep_and_control_tb
